// ==== port_zero_pkg.sv ====
// port zero gpio: register map, reset values and widths
`default_nettype none
package port_zero_pkg;
    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int PIN_COUNT = 8;
    localparam int ADR_WIDTH = 5;
    localparam int DAT_WIDTH = 32;
    localparam int SEL_WIDTH = 4;

    // ------------------------------------------------------------------
    // register byte offsets on the wishbone bus
    // ------------------------------------------------------------------
    localparam logic [ADR_WIDTH-1:0] OFS_OUTPUT_LATCH = 5'h00;
    localparam logic [ADR_WIDTH-1:0] OFS_DIRECTION = 5'h04;
    localparam logic [ADR_WIDTH-1:0] OFS_PULLUP_ENABLE = 5'h08;
    localparam logic [ADR_WIDTH-1:0] OFS_ANALOG_DISABLE = 5'h0C;
    localparam logic [ADR_WIDTH-1:0] OFS_STANDBY_CONTROL = 5'h10;

    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int STANDBY_FLOAT_POS = 0;
    localparam logic [7:0] RESET_OUTPUT_LATCH = 8'h00;
    localparam logic [7:0] RESET_DIRECTION = 8'h00;
    localparam logic [7:0] RESET_PULLUP_ENABLE = 8'h00;
    localparam logic [7:0] RESET_ANALOG_DISABLE = 8'h00;
    localparam logic RESET_STANDBY_FLOAT = 1'b0;
    // value returned for an address that holds no register
    localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

    // ------------------------------------------------------------------
    // shared-function pin positions
    // ------------------------------------------------------------------
    localparam int PIN_CMP_POS = 0;
    localparam int PIN_CMP_NEG = 1;
    localparam int PIN_SER_CLK = 2;
    localparam int PIN_SER_DOUT = 3;
    localparam int PIN_SER_DIN = 4;
    localparam int PIN_TMR_A = 5;
    localparam int PIN_TMR_B = 6;

    // number of flip-flops in the pin input synchroniser
    localparam int SYNC_STAGES = 2;
endpackage
`default_nettype wire

// ==== port_pin_cell.sv ====
// port zero gpio: combinational pad steering for one pin
`default_nettype none
module port_pin_cell
    import port_zero_pkg::*;
(
    // pin configuration
    input wire logic latch,
    input wire logic dir,
    input wire logic pull,
    input wire logic aid,
    // shared peripheral output
    input wire logic periph_oe,
    input wire logic periph_out,
    // synchronised pad level and standby state
    input wire logic pin_level,
    input wire logic float_force,
    input wire logic irq_enable,
    // pad drive
    output logic pin_out,
    output logic pin_oe,
    output logic pullup_on,
    // internal views of the pin
    output logic read_value,
    output logic digital_in,
    output logic irq_in
);
    logic port_drive;

    // ------------------------------------------------------------------
    // output path
    // ------------------------------------------------------------------
    // R10: direction drives latch
    // R13: standby float forces high-z
    assign port_drive = dir & ~periph_oe & ~float_force;
    assign pin_oe = (dir | periph_oe) & ~float_force;
    // R9: peripheral output takes over
    assign pin_out = pin_oe & (periph_oe ? periph_out : latch);

    // R15: pull-up only off-low
    // a low driver would fight the resistor and waste current
    assign pullup_on = pull & ~(pin_oe & ~pin_out);

    // ------------------------------------------------------------------
    // input path
    // ------------------------------------------------------------------
    // R12: analog disable gates input
    // R13: floated input held low
    assign digital_in = aid & ~float_force & pin_level;
    // R13: enabled interrupt keeps input
    assign irq_in = (float_force & ~irq_enable) ? 1'b0 : pin_level;

    // R11: latch or live level
    assign read_value = port_drive ? latch : digital_in;
endmodule // port_pin_cell
`default_nettype wire

// ==== port_zero_gpio.sv ====
// port zero gpio: wishbone register file, pin synchroniser and function mux
// Contract
// R1: never write unmapped; unmapped reads are undefined
// R2: rmw read returns latch, not pins
// R3: direction, pull-up, analog-disable read back written
// R4: all four port registers reset to zero
// R5: port is pins plus four control registers
// R6: pin n feeds interrupt n, channel n
// R7: pin 0/1 are comparator plus/minus
// R8: pins 2-4 serial clock/out/in, timer clock
// R9: pins 5/6 carry timer outputs when enabled
// R10: direction one drives latch, zero inputs
// R11: plain read: pin level unless port output
// R12: analog-disable zero blocks digital input
// R13: standby float: high-z, input low, irq kept
// R14: bit n controls pin n, eight bits
// R15: pull-up disconnected while driving low
//
// Our own choices: the placing of the registers and the Wishbone slave port.
`default_nettype none
module port_zero_gpio
    import port_zero_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // wishbone classic slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic lock_i,
    input wire logic [ADR_WIDTH-1:0] adr_i,
    input wire logic [SEL_WIDTH-1:0] sel_i,
    input wire logic [DAT_WIDTH-1:0] dat_i,
    output logic [DAT_WIDTH-1:0] dat_o,
    output logic ack_o,
    // pads
    input wire logic [PIN_COUNT-1:0] pin_in,
    output logic [PIN_COUNT-1:0] pin_out,
    output logic [PIN_COUNT-1:0] pin_oe,
    output logic [PIN_COUNT-1:0] pullup_on,
    // standby and external interrupt circuit
    input wire logic stop_or_watch_mode,
    input wire logic [PIN_COUNT-1:0] ext_irq_enable,
    output logic [PIN_COUNT-1:0] ext_irq_input_n,
    // a/d converter and comparator
    output logic [PIN_COUNT-1:0] adc_channel_input_n,
    output logic comparator_positive_in,
    output logic comparator_negative_in,
    // serial controller
    input wire logic serial_clock_oe,
    input wire logic serial_clock_out,
    output logic serial_clock_in,
    input wire logic serial_data_oe,
    input wire logic serial_data_out,
    output logic serial_data_in,
    // composite timer channel 0
    input wire logic timer_output_enable,
    input wire logic timer_output_a,
    input wire logic timer_output_b,
    output logic timer_external_clock_in
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    // R5: four control registers beside the pins
    typedef struct packed {
        logic [PIN_COUNT-1:0] latch;
        logic [PIN_COUNT-1:0] dir;
        logic [PIN_COUNT-1:0] pull;
        logic [PIN_COUNT-1:0] aid;
        logic float_en;
        logic ack;
        logic [7:0] rdata;
        logic [PIN_COUNT-1:0] sync_a;
        logic [PIN_COUNT-1:0] sync_b;
        logic first;
    } port_state_s;

    port_state_s state_reg;
    port_state_s state_next;

    logic bus_req;
    logic float_active;
    logic [PIN_COUNT-1:0] periph_oe;
    logic [PIN_COUNT-1:0] periph_out;
    logic [PIN_COUNT-1:0] read_value;
    logic [PIN_COUNT-1:0] digital_in;

    assign bus_req = cyc_i & stb_i;

    // R13: float only in stop or watch
    assign float_active = stop_or_watch_mode & state_reg.float_en;

    // ------------------------------------------------------------------
    // peripheral output map
    // ------------------------------------------------------------------
    // R8: serial clock and data out
    // R9: timer outputs on 5 and 6
    always_comb begin
        periph_oe = '0;
        periph_out = '0;
        periph_oe[PIN_SER_CLK] = serial_clock_oe;
        periph_out[PIN_SER_CLK] = serial_clock_out;
        periph_oe[PIN_SER_DOUT] = serial_data_oe;
        periph_out[PIN_SER_DOUT] = serial_data_out;
        periph_oe[PIN_TMR_A] = timer_output_enable;
        periph_out[PIN_TMR_A] = timer_output_a;
        periph_oe[PIN_TMR_B] = timer_output_enable;
        periph_out[PIN_TMR_B] = timer_output_b;
    end

    // ------------------------------------------------------------------
    // per-pin pad cells
    // ------------------------------------------------------------------
    // R14: bit n steers pin n
    for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
        port_pin_cell u_cell (
            .latch(state_reg.latch[i]),
            .dir(state_reg.dir[i]),
            .pull(state_reg.pull[i]),
            .aid(state_reg.aid[i]),
            .periph_oe(periph_oe[i]),
            .periph_out(periph_out[i]),
            .pin_level(state_reg.sync_b[i]),
            .float_force(float_active),
            .irq_enable(ext_irq_enable[i]),
            .pin_out(pin_out[i]),
            .pin_oe(pin_oe[i]),
            .pullup_on(pullup_on[i]),
            .read_value(read_value[i]),
            .digital_in(digital_in[i]),
            .irq_in(ext_irq_input_n[i])
        );
    end

    // ------------------------------------------------------------------
    // shared input functions
    // ------------------------------------------------------------------
    // R6: channel n is pin n
    // analog channel is selected while digital input is disabled and the direction bit is zero
    assign adc_channel_input_n = ~state_reg.aid & ~state_reg.dir;
    // R7: comparator inputs on pins 0 and 1
    // the comparator is analog; here it sees the digital level only
    assign comparator_positive_in = state_reg.sync_b[PIN_CMP_POS];
    assign comparator_negative_in = state_reg.sync_b[PIN_CMP_NEG];
    // R8: serial and timer clock inputs
    assign serial_clock_in = digital_in[PIN_SER_CLK];
    assign serial_data_in = digital_in[PIN_SER_DIN];
    assign timer_external_clock_in = digital_in[PIN_SER_DIN];

    // ------------------------------------------------------------------
    // next-state logic: bus slave and synchroniser
    // ------------------------------------------------------------------
    // one wait state: ack rises the cycle after the request; the write lands
    // on the edge that the master samples ack, so both see the same edge
    always_comb begin
        state_next = state_reg;
        state_next.first = 1'b0;
        // second stage reads only the first, nothing else taps sync_a
        state_next.sync_a = pin_in;
        state_next.sync_b = state_reg.sync_a;
        state_next.ack = bus_req & ~state_reg.ack;
        if (bus_req && !state_reg.ack && !we_i) begin
            case (adr_i)
                // R2: locked read returns latch
                // R11: plain read returns pin view
                OFS_OUTPUT_LATCH: begin
                    state_next.rdata = lock_i ? state_reg.latch : read_value;
                end
                // R3: plain storage readback
                OFS_DIRECTION: begin
                    state_next.rdata = state_reg.dir;
                end
                OFS_PULLUP_ENABLE: begin
                    state_next.rdata = state_reg.pull;
                end
                OFS_ANALOG_DISABLE: begin
                    state_next.rdata = state_reg.aid;
                end
                OFS_STANDBY_CONTROL: begin
                    state_next.rdata = 8'h00;
                    state_next.rdata[STANDBY_FLOAT_POS] = state_reg.float_en;
                end
                // R1: unmapped read, no fixed meaning
                default: begin
                    state_next.rdata = UNMAPPED_READ_VALUE;
                end
            endcase
        end
        if (bus_req && state_reg.ack && we_i && sel_i[0]) begin
            case (adr_i)
                // R10: latch takes writes always
                OFS_OUTPUT_LATCH: begin
                    state_next.latch = dat_i[7:0];
                end
                OFS_DIRECTION: begin
                    state_next.dir = dat_i[7:0];
                end
                OFS_PULLUP_ENABLE: begin
                    state_next.pull = dat_i[7:0];
                end
                OFS_ANALOG_DISABLE: begin
                    state_next.aid = dat_i[7:0];
                end
                OFS_STANDBY_CONTROL: begin
                    state_next.float_en = dat_i[STANDBY_FLOAT_POS];
                end
                // R1: unmapped write is dropped
                default: begin
                    state_next.float_en = state_reg.float_en;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    // R4: port registers clear on reset
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_reg.latch <= RESET_OUTPUT_LATCH;
            state_reg.dir <= RESET_DIRECTION;
            state_reg.pull <= RESET_PULLUP_ENABLE;
            state_reg.aid <= RESET_ANALOG_DISABLE;
            state_reg.float_en <= RESET_STANDBY_FLOAT;
            state_reg.ack <= 1'b0;
            state_reg.rdata <= 8'h00;
            state_reg.sync_a <= '0;
            state_reg.sync_b <= '0;
            state_reg.first <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    // bus outputs straight from flip-flops; upper lanes read zero
    assign dat_o = {24'h00_0000, state_reg.rdata};
    assign ack_o = state_reg.ack;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    sequence s_new_req;
        bus_req && !ack_o;
    endsequence

    sequence s_write_at(logic [ADR_WIDTH-1:0] ofs);
        bus_req && ack_o && we_i && sel_i[0] && adr_i == ofs;
    endsequence

    sequence s_read_at(logic [ADR_WIDTH-1:0] ofs);
        bus_req && ack_o && !we_i && adr_i == ofs;
    endsequence

    a_ack_one_wait: assert property (s_new_req |=> ack_o ##1 !ack_o) // R5
        else $error("ack not given one cycle after request");

    // R10: latch write stores
    a_latch_write: assert property (
        s_write_at(OFS_OUTPUT_LATCH) |=> state_reg.latch == $past(dat_i[7:0]))
        else $error("latch write not stored");

    // R3: direction written reads back
    a_dir_readback: assert property ( // R3
        s_write_at(OFS_DIRECTION) ##2 (s_new_req ##1 s_read_at(OFS_DIRECTION))
        |-> dat_o[7:0] == $past(dat_i[7:0], 4))
        else $error("direction readback differs from write");

    // R3: analog-disable readback
    a_store_read: assert property (
        s_read_at(OFS_ANALOG_DISABLE) |-> dat_o[7:0] == state_reg.aid
        && $stable(state_reg.aid))
        else $error("analog disable read differs from stored");

    // R2: locked read returns latch
    a_rmw_latch: assert property ( // R2
        s_read_at(OFS_OUTPUT_LATCH) ##0 lock_i |-> dat_o[7:0] == state_reg.latch)
        else $error("locked read did not return latch");

    // R4: registers zero after reset
    a_reset_zero: assert property (
        state_reg.first |-> state_reg.latch == 8'h00 && state_reg.dir == 8'h00
        && state_reg.pull == 8'h00 && state_reg.aid == 8'h00)
        else $error("port registers not cleared by reset");

    // R10: output drives latch value
    a_output_drive: assert property (
        !float_active |-> ((pin_oe & ~periph_oe) == (state_reg.dir & ~periph_oe))
        && ((pin_out & state_reg.dir & ~periph_oe)
        == (state_reg.latch & state_reg.dir & ~periph_oe)))
        else $error("port output does not follow latch");

    // R13: float forces high-z
    a_float_hiz: assert property (
        float_active |-> pin_oe == '0 && (digital_in == '0)
        && ((ext_irq_input_n & ~ext_irq_enable) == '0))
        else $error("standby float left a pin active");

    // R15: pull-up off while low
    a_pullup_low: assert property (
        (pullup_on & pin_oe & ~pin_out) == '0
        && ((pullup_on ^ state_reg.pull) & ~(pin_oe & ~pin_out)) == '0)
        else $error("pull-up wrong for driven level");

    // R12: analog disable blocks input
    a_analog_block: assert property ((digital_in & ~state_reg.aid) == '0)
        else $error("digital input passed with analog selected");

    // R6: interrupt follows pin two edges later
    a_irq_map: assert property (
        !float_active && $stable(pin_in) ##1 !float_active && $stable(pin_in)
        |-> ext_irq_input_n == $past(pin_in, 2))
        else $error("interrupt input not mapped to its pin");

    // R3: pull-up register readback
    a_pull_readback: assert property ( // R3
        s_read_at(OFS_PULLUP_ENABLE) |-> dat_o[7:0] == state_reg.pull)
        else $error("pull-up read differs from stored");

    // R11: plain read carries the pin view
    a_plain_read: assert property ( // R11
        s_read_at(OFS_OUTPUT_LATCH) ##0 !lock_i |-> dat_o[7:0] == $past(read_value))
        else $error("plain latch read lost the pin view");

    // R13: float bit reads back as stored
    a_float_readback: assert property ( // R13
        s_read_at(OFS_STANDBY_CONTROL) |-> dat_o[STANDBY_FLOAT_POS] == state_reg.float_en)
        else $error("standby float bit read differs from stored");

    // R13: enabled interrupt pins keep their level while floated
    a_irq_kept: assert property ( // R13
        float_active |-> (ext_irq_input_n & ext_irq_enable)
        == (state_reg.sync_b & ext_irq_enable))
        else $error("enabled interrupt input blocked in float");

    // R5: one ack per request, never two in a row
    a_ack_single: assert property (ack_o |=> !ack_o) // R5
        else $error("ack held for more than one cycle");
endmodule // port_zero_gpio
`default_nettype wire

// ==== pad_world_model.sv ====
// port zero gpio: external pads and board-side drivers seen from the pins
`default_nettype none
module pad_world_model (
    // clock
    input wire logic mclk,
    // design pad drive
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pullup_on,
    // board-side driver
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_level,
    // resolved pad level
    output logic [7:0] pad
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] float_reg = 8'h55;

    // an undriven pad with no pull-up wanders, so nothing may rely on its value
    always @(posedge mclk) begin
        float_reg <= ~float_reg;
    end

    // resolve each pad: design drive wins, then the board, then the pull-up
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe[i]) begin
                pad[i] = pin_out[i];
            end else if (ext_en[i]) begin
                pad[i] = ext_level[i];
            end else if (pullup_on[i]) begin
                pad[i] = 1'b1;
            end else begin
                pad[i] = float_reg[i];
            end
        end
    end
endmodule // pad_world_model
`default_nettype wire

// ==== port_zero_gpio_tb.sv ====
// port zero gpio: self-checking testbench
`default_nettype none
module port_zero_gpio_tb;
    import port_zero_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk, resetn, cyc_i, stb_i, we_i, lock_i, ack_o;
    logic [4:0] adr_i;
    logic [3:0] sel_i;
    logic [31:0] dat_i, dat_o, q;
    logic [7:0] pad, pin_out, pin_oe, pullup_on, irq_in, adc_in, irq_en, ext_en, ext_level;
    logic mode, cmp_p, cmp_n, sck_oe, sck_out, sck_in, sd_oe, sd_out, sd_in;
    logic tmr_en, tmr_a, tmr_b, tmr_clk;
    int fail_count = 0;
    int samples_checked = 0;

    port_zero_gpio dut (.mclk(mclk), .resetn(resetn), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .lock_i(lock_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .pin_in(pad), .pin_out(pin_out), .pin_oe(pin_oe),
        .pullup_on(pullup_on), .stop_or_watch_mode(mode), .ext_irq_enable(irq_en),
        .ext_irq_input_n(irq_in), .adc_channel_input_n(adc_in),
        .comparator_positive_in(cmp_p), .comparator_negative_in(cmp_n),
        .serial_clock_oe(sck_oe), .serial_clock_out(sck_out), .serial_clock_in(sck_in),
        .serial_data_oe(sd_oe), .serial_data_out(sd_out), .serial_data_in(sd_in),
        .timer_output_enable(tmr_en), .timer_output_a(tmr_a), .timer_output_b(tmr_b),
        .timer_external_clock_in(tmr_clk));

    pad_world_model board (.mclk(mclk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pullup_on(pullup_on), .ext_en(ext_en), .ext_level(ext_level), .pad(pad));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // classic cycle: hold the request until ack is seen, release after that edge
    task automatic wb(input logic [4:0] a, input logic w, input logic lk, input logic [7:0] d);
        @(posedge mclk);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        lock_i <= lk;
        adr_i <= a;
        sel_i <= 4'h1;
        dat_i <= {24'h00_0000, d};
        // ack and read data are taken at the rising edge; only the watchdog ends a hang
        @(posedge mclk);
        while (ack_o !== 1'b1) begin
            @(posedge mclk);
        end
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        lock_i <= 1'b0;
    endtask

    task automatic rdc(input string nm, input logic [4:0] a, input logic lk, input logic [7:0] e);
        wb(a, 1'b0, lk, 8'h00);
        chk(nm, {24'h00_0000, e}, q);
    endtask

    // let synchroniser and combinational pad logic settle before looking
    task automatic settle();
        repeat (3) @(posedge mclk);
        @(negedge mclk);
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        rdc("direction", OFS_DIRECTION, 1'b0, RESET_DIRECTION);
        rdc("pullup", OFS_PULLUP_ENABLE, 1'b0, RESET_PULLUP_ENABLE);
        rdc("analog", OFS_ANALOG_DISABLE, 1'b0, RESET_ANALOG_DISABLE);
        rdc("latch_rmw", OFS_OUTPUT_LATCH, 1'b1, RESET_OUTPUT_LATCH);
        rdc("unmapped", 5'h14, 1'b0, UNMAPPED_READ_VALUE);
        chk("oe_reset", 32'h0000_0000, {24'h00_0000, pin_oe});
        $display("test reset done");
    endtask

    task automatic t_storage();
        logic [7:0] pat [4] = '{8'h01, 8'h80, 8'hA5, 8'h5A};
        foreach (pat[i]) begin
            wb(OFS_PULLUP_ENABLE, 1'b1, 1'b0, ~pat[i]);
            wb(OFS_ANALOG_DISABLE, 1'b1, 1'b0, pat[i] ^ 8'h0F);
            wb(OFS_DIRECTION, 1'b1, 1'b0, pat[i]);
            rdc("direction", OFS_DIRECTION, 1'b0, pat[i]);
            rdc("pullup", OFS_PULLUP_ENABLE, 1'b0, ~pat[i]);
            rdc("analog", OFS_ANALOG_DISABLE, 1'b0, pat[i] ^ 8'h0F);
        end
        $display("test storage done");
    endtask

    task automatic t_output();
        wb(OFS_PULLUP_ENABLE, 1'b1, 1'b0, 8'hFF);
        wb(OFS_OUTPUT_LATCH, 1'b1, 1'b0, 8'h0F);
        wb(OFS_DIRECTION, 1'b1, 1'b0, 8'hFF);
        settle();
        chk("pin_oe", 32'h0000_00FF, {24'h00_0000, pin_oe});
        chk("pin_out", 32'h0000_000F, {24'h00_0000, pin_out});
        chk("pullup_on", 32'h0000_000F, {24'h00_0000, pullup_on});
        rdc("latch_out", OFS_OUTPUT_LATCH, 1'b0, 8'h0F);
        wb(OFS_PULLUP_ENABLE, 1'b1, 1'b0, 8'h00);
        wb(OFS_OUTPUT_LATCH, 1'b1, 1'b0, 8'hA5);
        $display("test output done");
    endtask

    task automatic t_input();
        wb(OFS_DIRECTION, 1'b1, 1'b0, 8'h00);
        wb(OFS_ANALOG_DISABLE, 1'b1, 1'b0, 8'hFF);
        ext_en <= 8'hFF;
        ext_level <= 8'h3D;
        settle();
        chk("oe_input", 32'h0000_0000, {24'h00_0000, pin_oe});
        rdc("latch_pins", OFS_OUTPUT_LATCH, 1'b0, 8'h3D);
        rdc("latch_rmw", OFS_OUTPUT_LATCH, 1'b1, 8'hA5);
        chk("irq", 32'h0000_003D, {24'h00_0000, irq_in});
        chk("adc", 32'h0000_0000, {24'h00_0000, adc_in});
        chk("cmp", 32'h0000_0001, {30'h0000_0000, cmp_n, cmp_p});
        chk("ser_tmr", 32'h0000_0007, {29'h0000_0000, sck_in, sd_in, tmr_clk});
        wb(OFS_ANALOG_DISABLE, 1'b1, 1'b0, 8'h00);
        settle();
        rdc("latch_blocked", OFS_OUTPUT_LATCH, 1'b0, 8'h00);
        chk("adc_on", 32'h0000_00FF, {24'h00_0000, adc_in});
        $display("test input done");
    endtask

    task automatic t_periph();
        wb(OFS_ANALOG_DISABLE, 1'b1, 1'b0, 8'hFF);
        tmr_en <= 1'b1;
        tmr_a <= 1'b1;
        sck_oe <= 1'b1;
        sck_out <= 1'b1;
        sd_oe <= 1'b1;
        settle();
        chk("oe_periph", 32'h0000_006C, {24'h00_0000, pin_oe});
        chk("out_periph", 32'h0000_0024, {24'h00_0000, pin_out});
        rdc("latch_periph", OFS_OUTPUT_LATCH, 1'b0, 8'h35);
        tmr_en <= 1'b0;
        sck_oe <= 1'b0;
        sd_oe <= 1'b0;
        $display("test peripheral done");
    endtask

    task automatic t_standby();
        wb(OFS_DIRECTION, 1'b1, 1'b0, 8'hFF);
        wb(OFS_STANDBY_CONTROL, 1'b1, 1'b0, 8'h01);
        rdc("float_bit", OFS_STANDBY_CONTROL, 1'b0, 8'h01);
        irq_en <= 8'h0F;
        mode <= 1'b1;
        settle();
        chk("oe_float", 32'h0000_0000, {24'h00_0000, pin_oe});
        chk("irq_float", 32'h0000_000D, {24'h00_0000, irq_in});
        rdc("latch_float", OFS_OUTPUT_LATCH, 1'b0, 8'h00);
        mode <= 1'b0;
        wb(OFS_STANDBY_CONTROL, 1'b1, 1'b0, 8'h00);
        $display("test standby done");
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // clock, watchdog and main sequence
    // ------------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // whole run is well under a thousand cycles, so this only fires on a hang
    initial begin
        repeat (5000) @(posedge mclk);
        fail_count++;
        tally_and_finish();
    end

    initial begin
        {cyc_i, stb_i, we_i, lock_i, mode, sck_oe, sck_out, sd_oe, sd_out} = '0;
        {tmr_en, tmr_a, tmr_b} = '0;
        adr_i = '0;
        sel_i = '0;
        dat_i = '0;
        irq_en = '0;
        ext_en = '0;
        ext_level = '0;
        resetn = 1'b0;
        repeat (20) @(posedge mclk);
        resetn <= 1'b1;
        t_reset();
        t_storage();
        t_output();
        t_input();
        t_periph();
        t_standby();
        tally_and_finish();
    end
endmodule // port_zero_gpio_tb
`default_nettype wire
